// *** axwf_defs.svh ***
// Register offsets, field positions, reset values and ECC injection taps
`ifndef AXWF_DEFS_SVH
`define AXWF_DEFS_SVH

`define AXWF_CTRL_OFF 8'h00
`define AXWF_STATUS_OFF 8'h04
`define AXWF_COUNT_OFF 8'h08
`define AXWF_THRESH_OFF 8'h0c

`define AXWF_CTRL_ECC_EN_BIT 0
`define AXWF_CTRL_RST 32'h0000_0001

`define AXWF_ST_PFULL_BIT 0
`define AXWF_ST_PEMPTY_BIT 1
`define AXWF_ST_FULL_BIT 2
`define AXWF_ST_EMPTY_BIT 3
`define AXWF_ST_SBIT_BIT 4
`define AXWF_ST_DBIT_BIT 5
`define AXWF_ST_OVF_BIT 6

`define AXWF_THR_PE_LSB 16

`define AXWF_INJ_POS_A 3
`define AXWF_INJ_POS_B 5

`endif

// *** axwf_pkg.sv ***
// Shared types of the write-data buffer sideband logic
package axwf_pkg;

  typedef enum logic [1:0] {
    AXWF_ECC_CLEAN,
    AXWF_ECC_FIXED,
    AXWF_ECC_BAD
  } axwf_ecc_res_t;

endpackage : axwf_pkg

// *** axwf_secded.sv ***
// Single-error-correcting, double-error-detecting Hamming codec
module axwf_secded
  import axwf_pkg::*;
#(
  parameter int K = 36,
  parameter int P = 6,
  parameter int CW = K + P + 1
) (
  input wire logic [K-1:0] enc_data,
  output logic [CW-1:0] enc_code,
  input wire logic [CW-1:0] dec_code,
  output logic [K-1:0] dec_data,
  output axwf_ecc_res_t dec_res
);

  ////////////////////////////////////////////////////////////////////////////
  // Encoder: data at non power-of-two positions, bit 0 is overall parity
  always_comb begin
    logic [CW-1:0] c;
    logic par;
    int j;
    c = '0;
    par = 1'b0;
    j = 0;
    for (int p = 1; p < CW; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = enc_data[j];
        j++;
      end
    end
    for (int i = 0; i < P; i++) begin
      par = 1'b0;
      for (int p = 1; p < CW; p++) begin
        if ((((p >> i) & 1) == 1) && (p != (1 << i))) begin
          par = par ^ c[p];
        end
      end
      c[1 << i] = par;
    end
    c[0] = ^c[CW-1:1];
    enc_code = c;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoder
  always_comb begin
    logic [P-1:0] syn;
    logic [CW-1:0] fixed;
    logic s;
    logic overall;
    int j;
    syn = '0;
    fixed = dec_code;
    s = 1'b0;
    j = 0;
    overall = ^dec_code;
    dec_data = '0;
    for (int i = 0; i < P; i++) begin
      s = 1'b0;
      for (int p = 1; p < CW; p++) begin
        if (((p >> i) & 1) == 1) begin
          s = s ^ dec_code[p];
        end
      end
      syn[i] = s;
    end
    if (syn == '0 && !overall) begin
      dec_res = AXWF_ECC_CLEAN;
    end else if (overall && (int'(syn) < CW)) begin
      // Syndrome zero with bad parity means only the parity bit flipped
      if (syn != '0) begin
        fixed[syn] = ~fixed[syn];
      end
      dec_res = AXWF_ECC_FIXED;
    end else begin
      dec_res = AXWF_ECC_BAD;
    end
    for (int p = 1; p < CW; p++) begin
      if ((p & (p - 1)) != 0) begin
        dec_data[j] = fixed[p];
        j++;
      end
    end
  end

endmodule : axwf_secded

// *** axwf_wdata_fifo.sv ***
// Write-data channel buffer with thresholds, counts, ECC and APB status
//
// Function
// - Full threshold input sets almost-full flag
// - Empty threshold input sets almost-empty flag
// - Thresholds captured at the first edge after reset release
// - Single injection corrupts one stored bit
// - Double injection corrupts two stored bits
// - Single-bit error corrected and flagged
// - Double-bit error flagged, data uncorrected
// - Overflow one cycle after write rejected while full, not during threshold capture
// - Rejected write leaves contents and pointers
// - Full buffer refuses writes, overflow raised
// - Write count never under-reports held words
// - Write counted from the following edge
// - Underflow output held low, never raised
// - Rejected read leaves contents and pointers
// - Empty buffer refuses reads, underflow low
// - Read count never over-reports available words
// - Read counted from the following edge
// - Common count gives words stored
// - Almost-full raised at or above threshold
// - Almost-full dropped below threshold
// - Almost-empty raised at or below threshold
// - Almost-empty dropped above threshold
// - Each entry holds data plus byte strobes
`include "axwf_defs.svh"

module axwf_wdata_fifo
  import axwf_pkg::*;
#(
  parameter int DW = 32,
  parameter int AW = 4,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [DW-1:0] s_axi_wdata,
  input wire logic [DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [DW-1:0] m_axi_wdata,
  output logic [DW/8-1:0] m_axi_wstrb,
  output logic m_axi_wvalid,
  input wire logic m_axi_wready,
  input wire logic [AW-1:0] prog_full_thresh,
  input wire logic [AW-1:0] prog_empty_thresh,
  input wire logic inject_sbit_err,
  input wire logic inject_dbit_err,
  output logic sbit_err,
  output logic dbit_err,
  output logic overflow,
  output logic underflow,
  output logic [AW:0] wr_data_count,
  output logic [AW:0] rd_data_count,
  output logic [AW:0] data_count,
  output logic prog_full,
  output logic prog_empty,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int SW = DW / 8;
  localparam int K = DW + SW;
  localparam int P = 6;
  localparam int CW = K + P + 1;

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] cnt;
    logic [AW-1:0] pf_thr;
    logic [AW-1:0] pe_thr;
    logic thr_ld;
    logic ecc_en;
    logic ovf;
    logic unf;
    logic pf;
    logic pe;
    logic out_vld;
    logic [DW-1:0] out_data;
    logic [SW-1:0] out_strb;
    logic sbit;
    logic dbit;
    logic sbit_seen;
    logic dbit_seen;
    logic ovf_seen;
    logic [31:0] prdata;
    logic pslverr;
  } axwf_state_t;

  axwf_state_t st_q;
  axwf_state_t st_d;

  logic [CW-1:0] mem [DEPTH];
  logic [CW-1:0] enc_code;
  logic [CW-1:0] wr_code;
  logic [K-1:0] dec_data;
  axwf_ecc_res_t dec_res;
  logic full;
  logic empty;
  logic push;
  logic pop;
  logic setup;
  logic access;
  logic bad_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Codec and storage
  axwf_secded #(
    .K(K),
    .P(P),
    .CW(CW)
  ) u_secded (
    .enc_data({s_axi_wstrb, s_axi_wdata}),
    .enc_code(enc_code),
    .dec_code(mem[st_q.rptr[AW-1:0]]),
    .dec_data(dec_data),
    .dec_res(dec_res)
  );

  always_comb begin
    wr_code = enc_code;
    if (st_q.ecc_en && inject_dbit_err) begin
      wr_code[`AXWF_INJ_POS_A] = ~enc_code[`AXWF_INJ_POS_A];
      wr_code[`AXWF_INJ_POS_B] = ~enc_code[`AXWF_INJ_POS_B];
    end else if (st_q.ecc_en && inject_sbit_err) begin
      wr_code[`AXWF_INJ_POS_A] = ~enc_code[`AXWF_INJ_POS_A];
    end
  end

  // No reset on the array, only pointers qualify its contents
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st_q.wptr[AW-1:0]] <= wr_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign full = (st_q.cnt == (AW+1)'(DEPTH));
  assign empty = (st_q.cnt == '0);
  // Held off until thresholds are captured after reset release
  assign s_axi_wready = st_q.thr_ld && !full;
  assign push = s_axi_wvalid && s_axi_wready;
  assign pop = !empty && (!st_q.out_vld || m_axi_wready);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign bad_addr = !(paddr == `AXWF_CTRL_OFF || paddr == `AXWF_STATUS_OFF ||
                      paddr == `AXWF_COUNT_OFF || paddr == `AXWF_THRESH_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    if (!st_q.thr_ld) begin
      st_d.pf_thr = prog_full_thresh;
      st_d.pe_thr = prog_empty_thresh;
      st_d.thr_ld = 1'b1;
    end
    if (push) begin
      st_d.wptr = st_q.wptr + (AW+1)'(1);
    end
    if (pop) begin
      st_d.rptr = st_q.rptr + (AW+1)'(1);
    end
    // One registered count serves all three outputs, so a transfer shows
    // from the next edge and the count is never off in either direction
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    st_d.pf = (st_d.cnt >= {1'b0, st_d.pf_thr});
    st_d.pe = (st_d.cnt <= {1'b0, st_d.pe_thr});
    st_d.ovf = s_axi_wvalid && st_q.thr_ld && full;
    st_d.unf = 1'b0;
    if (pop) begin
      st_d.out_vld = 1'b1;
      st_d.out_data = dec_data[DW-1:0];
      st_d.out_strb = dec_data[K-1:DW];
      st_d.sbit = st_q.ecc_en && (dec_res == AXWF_ECC_FIXED);
      st_d.dbit = st_q.ecc_en && (dec_res == AXWF_ECC_BAD);
    end else if (m_axi_wready) begin
      st_d.out_vld = 1'b0;
      st_d.sbit = 1'b0;
      st_d.dbit = 1'b0;
    end
    // Register write, then sticky set so an event beats its clear
    if (access && pwrite && !st_q.pslverr) begin
      if (paddr == `AXWF_CTRL_OFF) begin
        st_d.ecc_en = pwdata[`AXWF_CTRL_ECC_EN_BIT];
      end
      if (paddr == `AXWF_STATUS_OFF) begin
        if (pwdata[`AXWF_ST_SBIT_BIT]) st_d.sbit_seen = 1'b0;
        if (pwdata[`AXWF_ST_DBIT_BIT]) st_d.dbit_seen = 1'b0;
        if (pwdata[`AXWF_ST_OVF_BIT]) st_d.ovf_seen = 1'b0;
      end
    end
    if (st_d.sbit && pop) st_d.sbit_seen = 1'b1;
    if (st_d.dbit && pop) st_d.dbit_seen = 1'b1;
    if (st_d.ovf) st_d.ovf_seen = 1'b1;
    // Read data and error are settled in the setup cycle
    if (setup) begin
      st_d.prdata = '0;
      st_d.pslverr = bad_addr;
      if (!pwrite) begin
        unique case (1'b1)
          paddr == `AXWF_CTRL_OFF: st_d.prdata[`AXWF_CTRL_ECC_EN_BIT] = st_q.ecc_en;
          paddr == `AXWF_STATUS_OFF: begin
            st_d.prdata[`AXWF_ST_PFULL_BIT] = st_q.pf;
            st_d.prdata[`AXWF_ST_PEMPTY_BIT] = st_q.pe;
            st_d.prdata[`AXWF_ST_FULL_BIT] = full;
            st_d.prdata[`AXWF_ST_EMPTY_BIT] = empty;
            st_d.prdata[`AXWF_ST_SBIT_BIT] = st_q.sbit_seen;
            st_d.prdata[`AXWF_ST_DBIT_BIT] = st_q.dbit_seen;
            st_d.prdata[`AXWF_ST_OVF_BIT] = st_q.ovf_seen;
          end
          paddr == `AXWF_COUNT_OFF: st_d.prdata[AW:0] = st_q.cnt;
          paddr == `AXWF_THRESH_OFF: begin
            st_d.prdata[AW-1:0] = st_q.pf_thr;
            st_d.prdata[`AXWF_THR_PE_LSB +: AW] = st_q.pe_thr;
          end
          default: st_d.prdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.pe <= 1'b1;
      st_q.ecc_en <= 1'(`AXWF_CTRL_RST >> `AXWF_CTRL_ECC_EN_BIT);
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign m_axi_wvalid = st_q.out_vld;
  assign m_axi_wdata = st_q.out_data;
  assign m_axi_wstrb = st_q.out_strb;
  assign sbit_err = st_q.sbit;
  assign dbit_err = st_q.dbit;
  assign overflow = st_q.ovf;
  assign underflow = st_q.unf;
  assign wr_data_count = st_q.cnt;
  assign rd_data_count = st_q.cnt;
  assign data_count = st_q.cnt;
  assign prog_full = st_q.pf;
  assign prog_empty = st_q.pe;
  assign prdata = st_q.prdata;
  assign pready = access;
  assign pslverr = access && st_q.pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_thr_capture;
    $rose(st_q.thr_ld) |-> st_q.pf_thr == $past(prog_full_thresh) &&
      st_q.pe_thr == $past(prog_empty_thresh);
  endproperty
  a_thr_capture: assert property (p_thr_capture) else $error("threshold not captured");

  property p_inj_single;
    st_q.ecc_en && inject_sbit_err && !inject_dbit_err |-> $countones(wr_code ^ enc_code) == 1;
  endproperty
  a_inj_single: assert property (p_inj_single) else $error("single injection wrong");

  property p_inj_double;
    st_q.ecc_en && inject_dbit_err |-> $countones(wr_code ^ enc_code) == 2;
  endproperty
  a_inj_double: assert property (p_inj_double) else $error("double injection wrong");

  property p_err_excl;
    !(sbit_err && dbit_err) && (!(sbit_err || dbit_err) || m_axi_wvalid);
  endproperty
  a_err_excl: assert property (p_err_excl) else $error("error flags inconsistent");

  property p_ovf;
    s_axi_wvalid && !s_axi_wready && st_q.thr_ld |=> overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missing");

  property p_full_hold;
    full && s_axi_wvalid |=> $stable(st_q.wptr) && data_count <= $past(data_count);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full buffer accepted write");

  property p_count_step;
    push && !pop |=> data_count == (AW+1)'($past(data_count) + 1'b1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("write count step wrong");

  property p_empty_hold;
    empty && !push |=> $stable(st_q.rptr) && !underflow && data_count == '0;
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty buffer popped");

  property p_pf;
    st_q.thr_ld |-> (prog_full == (data_count >= {1'b0, st_q.pf_thr}));
  endproperty
  a_pf: assert property (p_pf) else $error("almost-full mismatch");

  property p_pe_drop;
    st_q.thr_ld && (data_count > {1'b0, st_q.pe_thr}) |-> !prog_empty;
  endproperty
  a_pe_drop: assert property (p_pe_drop) else $error("almost-empty mismatch");

  property p_pe_rise;
    st_q.thr_ld && (data_count <= {1'b0, st_q.pe_thr}) |-> prog_empty;
  endproperty
  a_pe_rise: assert property (p_pe_rise) else $error("almost-empty not raised");

  property p_rd_step;
    pop && !push |=> data_count == (AW+1)'($past(data_count) - 1'b1);
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read count step wrong");

  property p_sbit_flag;
    pop && st_q.ecc_en && (dec_res == AXWF_ECC_FIXED) |=> sbit_err && !dbit_err;
  endproperty
  a_sbit_flag: assert property (p_sbit_flag) else $error("single error not flagged");

  property p_dbit_flag;
    pop && st_q.ecc_en && (dec_res == AXWF_ECC_BAD) |=> dbit_err && !sbit_err;
  endproperty
  a_dbit_flag: assert property (p_dbit_flag) else $error("double error not flagged");

  property p_cnt_range;
    data_count <= (AW+1)'(DEPTH);
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("count out of range");

  c_full: cover property (st_q.thr_ld ##1 full);
  c_pf_rise: cover property ($rose(prog_full));
  c_sbit: cover property (sbit_err);
  c_dbit: cover property (dbit_err);

endmodule : axwf_wdata_fifo

// *** axwf_sink.sv ***
// Downstream write-data slave model that drains the buffer output
module axwf_sink (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic rnd,
  output logic m_axi_wready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready wanders randomly unless hold forces it low, so the buffer sees both prompt and slow draining
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      m_axi_wready <= 1'b0;
    end else begin
      m_axi_wready <= !hold && rnd;
    end
  end
endmodule : axwf_sink

// *** test_axil_wdata_fifo_sideband.sv ***
// Self-checking bench of the write-data buffer against a reference queue
module test_axil_wdata_fifo_sideband;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, s_axi_wvalid, s_axi_wready, m_axi_wvalid, m_axi_wready;
  logic [31:0] s_axi_wdata, m_axi_wdata, pwdata, prdata, rng, rd;
  logic [3:0] s_axi_wstrb, m_axi_wstrb, pf_thr, pe_thr;
  logic inj_s, inj_d, sbit_err, dbit_err, overflow, underflow, prog_full, prog_empty;
  logic [4:0] wr_cnt, rd_cnt, data_count;
  logic psel, penable, pwrite, pready, pslverr, hold, rdy_rnd, mon_on, ecc_en, ov, ovf_e, er;
  logic [7:0] paddr;
  logic [37:0] mem[$];
  logic [37:0] ov_w, got_w, exp_w;
  int mode, n_fail, samples_checked, sz;

  axwf_wdata_fifo #(.DW(32), .AW(4), .DEPTH(16)) DUT (
    .sys_clk(sys_clk), .rst(rst), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .m_axi_wdata(m_axi_wdata),
    .m_axi_wstrb(m_axi_wstrb), .m_axi_wvalid(m_axi_wvalid), .m_axi_wready(m_axi_wready),
    .prog_full_thresh(pf_thr), .prog_empty_thresh(pe_thr), .inject_sbit_err(inj_s),
    .inject_dbit_err(inj_d), .sbit_err(sbit_err), .dbit_err(dbit_err), .overflow(overflow),
    .underflow(underflow), .wr_data_count(wr_cnt), .rd_data_count(rd_cnt),
    .data_count(data_count), .prog_full(prog_full), .prog_empty(prog_empty), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  axwf_sink snk (.sys_clk(sys_clk), .rst(rst), .hold(hold), .rnd(rdy_rnd),
    .m_axi_wready(m_axi_wready));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  task automatic chk_val(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: status %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_out(logic [37:0] got, logic [37:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // Waits as long as the slave stalls; only the watchdog ends a hung transfer
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Upstream master: holds valid and payload until accepted
  always @(posedge sys_clk) begin
    rng = lfsr(rng);
    rdy_rnd <= rng[13] | rng[14];
    if (!s_axi_wvalid || s_axi_wready) begin
      s_axi_wvalid <= (mode == 2) || (mode != 0 && rng[0]);
      s_axi_wdata <= rng;
      s_axi_wstrb <= rng[7:4];
      inj_s <= mode == 3 && rng[9:8] == 2'h0;
      inj_d <= mode == 3 && rng[11:10] == 2'h0;
    end
  end

  // Reference: storage queue plus one output word, full at sixteen stored
  always @(posedge sys_clk) begin
    if (mon_on) begin
      ovf_e = s_axi_wvalid && mem.size() == 16;
      if (ov && m_axi_wready) ov = 1'b0;
      if (!ov && mem.size() > 0) begin
        ov_w = mem.pop_front();
        ov = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        mem.push_back({ecc_en ? (inj_d ? 2'h2 : {1'b0, inj_s}) : 2'h0, s_axi_wstrb, s_axi_wdata});
      end
      #1;
      sz = mem.size();
      chk_val({data_count, wr_cnt, rd_cnt}, {3{5'(sz)}});
      chk_val(prog_full, sz >= pf_thr);
      chk_val(prog_empty, sz <= pe_thr);
      chk_val({s_axi_wready, m_axi_wvalid}, {sz != 16, ov});
      chk_val({overflow, underflow}, {ovf_e, 1'b0});
      got_w = {sbit_err, dbit_err, m_axi_wstrb, ov_w[37] ? 32'h0 : m_axi_wdata};
      exp_w = {ov_w[36], ov_w[37], ov_w[35:32], ov_w[37] ? 32'h0 : ov_w[31:0]};
      if (ov) chk_out(got_w, exp_w);
    end
  end

  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rng = 32'h74c48184;
    rst = 1'b1;
    mode = 0;
    hold = 1'b1;
    mon_on = 1'b0;
    ecc_en = 1'b1;
    ov = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    inj_s = 1'b0;
    inj_d = 1'b0;
    rdy_rnd = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pf_thr = 4'h5;
    pe_thr = 4'h9;
    repeat (2) @(posedge sys_clk);
    pf_thr <= 4'hc;
    pe_thr <= 4'h3;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    mon_on <= 1'b1;
    mode <= 2;
    repeat (24) @(posedge sys_clk);
    apb(1'b0, 8'h08, 32'h0);
    chk_val(rd, 32'h10);
    mode <= 0;
    hold <= 1'b0;
    repeat (60) @(posedge sys_clk);
    mode <= 3;
    repeat (400) @(posedge sys_clk);
    mode <= 0;
    repeat (40) @(posedge sys_clk);
    apb(1'b0, 8'h04, 32'h0);
    chk_val(rd, 32'h7a);
    apb(1'b1, 8'h04, 32'h70);
    apb(1'b0, 8'h04, 32'h0);
    chk_val(rd, 32'h0a);
    apb(1'b0, 8'h00, 32'h0);
    chk_val(rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk_val(rd, {12'h0, pe_thr, 12'h0, pf_thr});
    apb(1'b0, 8'h10, 32'h0);
    chk_val(rd, 32'h0);
    chk_val({31'h0, er}, 32'h1);
    // Correction off: injection must leave data and error outputs clean
    apb(1'b1, 8'h00, 32'h0);
    ecc_en <= 1'b0;
    mode <= 3;
    repeat (200) @(posedge sys_clk);
    mode <= 0;
    repeat (40) @(posedge sys_clk);
    apb(1'b0, 8'h04, 32'h0);
    chk_val(rd, 32'h0a);
    conclude();
  end
endmodule : test_axil_wdata_fifo_sideband
